//--- hw/result_transfer_engine.sv
// Instruction-driven engine moving converter results into data memory
//
// Functional notes
// - Instruction store holds 64 entries of 8 bits each.
// - Writing the data port stores the byte at the write pointer entry.
// - Reading the data port returns the byte at the write pointer entry.
// - Every data port read or write advances the write pointer by one.
// - Instructions only select results to collect; engine never starts conversions.
// - Each non end instruction writes 2 or 4 bytes.
// - Low seven bits zero is end of operation; bit 7 means continuous.
// - Pattern x0010000 collects converter 0 as one record.
// - Pattern x0100000 collects converter 1 as one record.
// - Pattern x0110000 collects both converters as two records.
// - Differential patterns write differential record, optionally plus converter 1 record.
// - On-chip writes only in cycles the core leaves that memory idle.
// - Halt 0 gives engine off-chip memory; halt 1 holds engine writes.
// - With halt 0, core off-chip accesses complete but transfer nothing.
// - New result before previous written raises overflow; new result may drop.
// - 16-bit write pointer loads from start address, steps 2 or 4.
// - Each cycle starts at boundary, fetches, waits for results.
// - Mode 0 runs each instruction once then advances status pointer.
// - End of operation reloads status pointer with boundary.
// - Continuous end instruction ignores repeat counter and loops forever.
// - Non continuous end decrements counter; stops at zero.
// - Repeat counter loads from limit at start of operation.
// - Converters not requested stay under processor control.
// - Enable write 1 starts, 0 stops; reads 1 while busy.
// - Mode select 0 chooses mode 0, 1 chooses mode 1; the code only stores and reads back the bit and always runs mode 0.
// - Busy flag reads 1 during engine off-chip access.
// - Completion sets sticky complete flag until software clears it.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module result_transfer_engine #(
	parameter int unsigned DEPTH = xfer_pkg::INSTR_DEPTH
) (
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        conv0_done_i,
	input  wire logic [15:0] conv0_result_i,
	input  wire logic        conv1_done_i,
	input  wire logic [15:0] conv1_result_i,
	input  wire logic [15:0] diff_result_i,
	input  wire logic        core_onchip_busy_i,
	input  wire logic        offchip_sel_i,
	output logic             mem_wr_o,
	output logic      [15:0] mem_addr_o,
	output logic      [15:0] mem_data_o,
	output logic             mem_offchip_o,
	output logic             core_offchip_grant_o,
	output logic             conv0_claimed_o,
	output logic             conv1_claimed_o
);

	////////////////////////////////////////////////////////////////////////////
	// State
	logic [7:0]                 store_q [DEPTH];
	logic [7:0]                 store_d [DEPTH];
	logic [xfer_pkg::INSTR_AW-1:0] iwp_q, iwp_d, isp_q, isp_d, bnd_q, bnd_d;
	xfer_pkg::seq_state_e       st_q, st_d;
	logic [7:0]                 ins_q, ins_d, rdata_q, rdata_d;
	logic [15:0]                start_q, start_d, wptr_q, wptr_d, lim_q, lim_d, cnt_q, cnt_d;
	logic [15:0]                rec0_q, rec0_d, rec1_q, rec1_d;
	logic                       got0_q, got0_d, got1_q, got1_d;
	logic                       mode_q, mode_d, halt_q, halt_d, done_q, done_d, eop_q, eop_d;
	logic                       err0_q, err0_d, err1_q, err1_d, warn0_q, warn0_d, warn1_q, warn1_d;
	logic                       two_q, two_d;
	xfer_pkg::mem_wr_s          wr_q, wr_d;
	logic                       busy_q, busy_d;

	////////////////////////////////////////////////////////////////////////////
	// Next state
	logic need0, need1, want_diff, can_write, en_wr;
	always_comb
	begin
		store_d = store_q;
		iwp_d = iwp_q;
		isp_d = isp_q;
		bnd_d = bnd_q;
		st_d = st_q;
		ins_d = ins_q;
		rdata_d = xfer_pkg::BYTE_ZERO;
		start_d = start_q;
		wptr_d = wptr_q;
		lim_d = lim_q;
		cnt_d = cnt_q;
		rec0_d = rec0_q;
		rec1_d = rec1_q;
		got0_d = got0_q;
		got1_d = got1_q;
		mode_d = mode_q;
		halt_d = halt_q;
		done_d = done_q;
		eop_d = eop_q;
		err0_d = err0_q;
		err1_d = err1_q;
		warn0_d = warn0_q;
		warn1_d = warn1_q;
		two_d = two_q;
		wr_d = '0;
		busy_d = 1'b0;
		want_diff = ins_q[xfer_pkg::INS_DIFF];
		need0 = ins_q[xfer_pkg::INS_C0] | want_diff;
		need1 = ins_q[xfer_pkg::INS_C1];
		// On-chip writes yield to the core; off-chip writes yield to halt
		can_write = offchip_sel_i ? !halt_q : !core_onchip_busy_i;
		en_wr = reg_wr_i && reg_addr_i == xfer_pkg::REG_CTRL;

		// Register writes; clears come first so hardware sets below win
		if (reg_wr_i)
		begin
			if (reg_addr_i == xfer_pkg::REG_CTRL)
			begin
				mode_d = reg_wdata_i[xfer_pkg::CTRL_MODE];
				done_d = done_q & reg_wdata_i[xfer_pkg::CTRL_DONE];
				err1_d = err1_q & reg_wdata_i[xfer_pkg::CTRL_ERR1];
				err0_d = err0_q & reg_wdata_i[xfer_pkg::CTRL_ERR0];
				warn1_d = warn1_q & reg_wdata_i[xfer_pkg::CTRL_WARN1];
				warn0_d = warn0_q & reg_wdata_i[xfer_pkg::CTRL_WARN0];
			end
			else if (reg_addr_i == xfer_pkg::REG_CFG)
			begin
				halt_d = reg_wdata_i[xfer_pkg::CFG_HALT];
				eop_d = eop_q & reg_wdata_i[xfer_pkg::CFG_EOP];
			end
			else if (reg_addr_i == xfer_pkg::REG_IPTR)
				iwp_d = reg_wdata_i[xfer_pkg::INSTR_AW-1:0];
			else if (reg_addr_i == xfer_pkg::REG_IDATA)
			begin
				store_d[iwp_q] = reg_wdata_i;
				iwp_d = iwp_q + 1'b1;
			end
			else if (reg_addr_i == xfer_pkg::REG_BOUND)
				bnd_d = reg_wdata_i[xfer_pkg::INSTR_AW-1:0];
			else if (reg_addr_i == xfer_pkg::REG_START_HI)
				start_d[15:8] = reg_wdata_i;
			else if (reg_addr_i == xfer_pkg::REG_START_LO)
				start_d[7:0] = reg_wdata_i;
			else if (reg_addr_i == xfer_pkg::REG_LIMIT_HI)
				lim_d[15:8] = reg_wdata_i;
			else if (reg_addr_i == xfer_pkg::REG_LIMIT_LO)
				lim_d[7:0] = reg_wdata_i;
		end

		// Register reads
		if (reg_rd_i)
		begin
			if (reg_addr_i == xfer_pkg::REG_CTRL)
				rdata_d = {st_q != xfer_pkg::ST_IDLE, done_q, mode_q, err1_q, err0_q, 1'b0, warn1_q, warn0_q};
			else if (reg_addr_i == xfer_pkg::REG_CFG)
				rdata_d = {halt_q, busy_q, 5'b0_0000, eop_q};
			else if (reg_addr_i == xfer_pkg::REG_IPTR)
				rdata_d = {2'b00, iwp_q};
			else if (reg_addr_i == xfer_pkg::REG_IDATA)
			begin
				rdata_d = store_q[iwp_q];
				iwp_d = iwp_q + 1'b1;
			end
			else if (reg_addr_i == xfer_pkg::REG_BOUND)
				rdata_d = {2'b00, bnd_q};
			else if (reg_addr_i == xfer_pkg::REG_ISTAT)
				rdata_d = {2'b00, isp_q};
			else if (reg_addr_i == xfer_pkg::REG_START_HI)
				rdata_d = start_q[15:8];
			else if (reg_addr_i == xfer_pkg::REG_START_LO)
				rdata_d = start_q[7:0];
			else if (reg_addr_i == xfer_pkg::REG_WPTR_HI)
				rdata_d = wptr_q[15:8];
			else if (reg_addr_i == xfer_pkg::REG_WPTR_LO)
				rdata_d = wptr_q[7:0];
			else if (reg_addr_i == xfer_pkg::REG_LIMIT_HI)
				rdata_d = lim_q[15:8];
			else if (reg_addr_i == xfer_pkg::REG_LIMIT_LO)
				rdata_d = lim_q[7:0];
			else if (reg_addr_i == xfer_pkg::REG_COUNT_HI)
				rdata_d = cnt_q[15:8];
			else if (reg_addr_i == xfer_pkg::REG_COUNT_LO)
				rdata_d = cnt_q[7:0];
		end

		// Result capture into the one-deep buffer per converter
		if (st_q != xfer_pkg::ST_IDLE && st_q != xfer_pkg::ST_FETCH && need0 && conv0_done_i)
		begin
			if (got0_q)
			begin
				warn0_d = 1'b1;
				err0_d = err0_q | warn0_q;
			end
			else
			begin
				got0_d = 1'b1;
				rec0_d = want_diff ? diff_result_i : conv0_result_i;
			end
		end
		if (st_q != xfer_pkg::ST_IDLE && st_q != xfer_pkg::ST_FETCH && need1 && conv1_done_i)
		begin
			if (got1_q)
			begin
				warn1_d = 1'b1;
				err1_d = err1_q | warn1_q;
			end
			else
			begin
				got1_d = 1'b1;
				rec1_d = conv1_result_i;
			end
		end

		case (st_q)
			xfer_pkg::ST_IDLE:
			begin
				if (en_wr && reg_wdata_i[xfer_pkg::CTRL_EN])
				begin
					wptr_d = start_q;
					cnt_d = lim_q;
					isp_d = bnd_q;
					done_d = 1'b0;
					got0_d = 1'b0;
					got1_d = 1'b0;
					st_d = xfer_pkg::ST_FETCH;
				end
			end
			xfer_pkg::ST_FETCH:
			begin
				ins_d = store_q[isp_q];
				got0_d = 1'b0;
				got1_d = 1'b0;
				if (store_q[isp_q][6:0] == xfer_pkg::INS_EOP_LOW)
				begin
					eop_d = 1'b1;
					isp_d = bnd_q;
					if (!store_q[isp_q][xfer_pkg::INS_CONT])
					begin
						cnt_d = cnt_q - xfer_pkg::COUNT_ONE;
						if (cnt_q == xfer_pkg::COUNT_ONE || cnt_q == xfer_pkg::COUNT_ZERO)
						begin
							cnt_d = xfer_pkg::COUNT_ZERO;
							done_d = 1'b1;
							st_d = xfer_pkg::ST_IDLE;
						end
					end
				end
				else
					st_d = xfer_pkg::ST_WAIT;
			end
			xfer_pkg::ST_WAIT:
			begin
				// Write order follows the instruction table: converter 1 first for converter pairs, differential record first for differential pairs
				if ((!need0 || got0_q) && (!need1 || got1_q))
				begin
					two_d = need0 && need1;
					st_d = xfer_pkg::ST_WR0;
				end
			end
			xfer_pkg::ST_WR0:
			begin
				if (can_write)
				begin
					wr_d.valid = 1'b1;
					wr_d.addr = wptr_q;
					// Single records pick their converter; converter pairs lead with converter 1, differential pairs with the differential record
					wr_d.data = (need1 && !want_diff) ? rec1_q : rec0_q;
					busy_d = offchip_sel_i;
					wptr_d = wptr_q + xfer_pkg::PTR_STEP;
					st_d = two_q ? xfer_pkg::ST_WR1 : xfer_pkg::ST_FETCH;
					if (!two_q)
						isp_d = isp_q + 1'b1;
				end
			end
			xfer_pkg::ST_WR1:
			begin
				if (can_write)
				begin
					wr_d.valid = 1'b1;
					wr_d.addr = wptr_q;
					wr_d.data = want_diff ? rec1_q : rec0_q;
					busy_d = offchip_sel_i;
					wptr_d = wptr_q + xfer_pkg::PTR_STEP;
					isp_d = isp_q + 1'b1;
					st_d = xfer_pkg::ST_FETCH;
				end
			end
			default:
				st_d = xfer_pkg::ST_IDLE;
		endcase

		// Writing 0 to enable stops the engine at once; buffered results drop
		if (en_wr && !reg_wdata_i[xfer_pkg::CTRL_EN] && st_q != xfer_pkg::ST_IDLE)
			st_d = xfer_pkg::ST_IDLE;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clock_i)
	begin
		store_q <= store_d;
		if (reset_i)
		begin
			iwp_q <= '0;
			isp_q <= '0;
			bnd_q <= '0;
			st_q <= xfer_pkg::ST_IDLE;
			ins_q <= xfer_pkg::BYTE_ZERO;
			rdata_q <= xfer_pkg::BYTE_ZERO;
			start_q <= xfer_pkg::COUNT_ZERO;
			wptr_q <= xfer_pkg::COUNT_ZERO;
			lim_q <= xfer_pkg::COUNT_ZERO;
			cnt_q <= xfer_pkg::COUNT_ZERO;
			rec0_q <= xfer_pkg::COUNT_ZERO;
			rec1_q <= xfer_pkg::COUNT_ZERO;
			{got0_q, got1_q, mode_q, halt_q, done_q, eop_q, two_q, busy_q} <= '0;
			{err0_q, err1_q, warn0_q, warn1_q} <= '0;
			wr_q <= '0;
		end
		else
		begin
			iwp_q <= iwp_d;
			isp_q <= isp_d;
			bnd_q <= bnd_d;
			st_q <= st_d;
			ins_q <= ins_d;
			rdata_q <= rdata_d;
			start_q <= start_d;
			wptr_q <= wptr_d;
			lim_q <= lim_d;
			cnt_q <= cnt_d;
			rec0_q <= rec0_d;
			rec1_q <= rec1_d;
			{got0_q, got1_q, mode_q, halt_q, done_q, eop_q, two_q, busy_q} <=
				{got0_d, got1_d, mode_d, halt_d, done_d, eop_d, two_d, busy_d};
			{err0_q, err1_q, warn0_q, warn1_q} <= {err0_d, err1_d, warn0_d, warn1_d};
			wr_q <= wr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, each straight from a flip-flop
	logic offchip_q, claim0_q, claim1_q;
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			offchip_q <= 1'b0;
			claim0_q <= 1'b0;
			claim1_q <= 1'b0;
		end
		else
		begin
			offchip_q <= offchip_sel_i;
			claim0_q <= st_d != xfer_pkg::ST_IDLE && st_d != xfer_pkg::ST_FETCH && need0;
			claim1_q <= st_d != xfer_pkg::ST_IDLE && st_d != xfer_pkg::ST_FETCH && need1;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign mem_wr_o = wr_q.valid;
	assign mem_addr_o = wr_q.addr;
	assign mem_data_o = wr_q.data;
	assign mem_offchip_o = offchip_q;
	assign core_offchip_grant_o = halt_q;
	assign conv0_claimed_o = claim0_q;
	assign conv1_claimed_o = claim1_q;

endmodule : result_transfer_engine

//--- hw/xfer_pkg.sv
// Shared constants, types and register map for the result transfer engine
package xfer_pkg;

	localparam int unsigned INSTR_DEPTH     = 64;
	localparam int unsigned INSTR_AW        = 6;
	localparam int unsigned INSTR_W         = 8;

	// Register offsets on the plain register port
	localparam logic [7:0] REG_CTRL         = 8'h00;
	localparam logic [7:0] REG_CFG          = 8'h01;
	localparam logic [7:0] REG_IPTR         = 8'h02;
	localparam logic [7:0] REG_IDATA        = 8'h03;
	localparam logic [7:0] REG_BOUND        = 8'h04;
	localparam logic [7:0] REG_ISTAT        = 8'h05;
	localparam logic [7:0] REG_START_HI     = 8'h06;
	localparam logic [7:0] REG_START_LO     = 8'h07;
	localparam logic [7:0] REG_WPTR_HI      = 8'h08;
	localparam logic [7:0] REG_WPTR_LO      = 8'h09;
	localparam logic [7:0] REG_LIMIT_HI     = 8'h0A;
	localparam logic [7:0] REG_LIMIT_LO     = 8'h0B;
	localparam logic [7:0] REG_COUNT_HI     = 8'h0C;
	localparam logic [7:0] REG_COUNT_LO     = 8'h0D;

	// Control register bits
	localparam int unsigned CTRL_EN         = 7;
	localparam int unsigned CTRL_DONE       = 6;
	localparam int unsigned CTRL_MODE       = 5;
	localparam int unsigned CTRL_ERR1       = 4;
	localparam int unsigned CTRL_ERR0       = 3;
	localparam int unsigned CTRL_WARN1      = 1;
	localparam int unsigned CTRL_WARN0      = 0;
	// Config register bits
	localparam int unsigned CFG_HALT        = 7;
	localparam int unsigned CFG_BUSY        = 6;
	localparam int unsigned CFG_EOP         = 0;

	// Instruction fields
	localparam int unsigned INS_CONT        = 7;
	localparam int unsigned INS_DIFF        = 6;
	localparam int unsigned INS_C1          = 5;
	localparam int unsigned INS_C0          = 4;
	localparam logic [6:0]  INS_EOP_LOW     = 7'h00;

	localparam logic [15:0] PTR_STEP        = 16'h0002;
	localparam logic [15:0] COUNT_ZERO      = 16'h0000;
	localparam logic [15:0] COUNT_ONE       = 16'h0001;
	localparam logic [7:0]  BYTE_ZERO       = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_FETCH = 3'b001,
		ST_WAIT  = 3'b010,
		ST_WR0   = 3'b011,
		ST_WR1   = 3'b100
	} seq_state_e;

	// One memory write request
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [15:0] data;
	} mem_wr_s;

endpackage : xfer_pkg

//--- test/conv_core_model.sv
// Converter pair and core memory traffic seen by the transfer engine
`timescale 1ns/1ps

module conv_core_model (
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  period_i,
	input  wire logic        core_load_i,
	output logic             conv0_done_o,
	output logic             conv1_done_o,
	output logic      [15:0] conv0_result_o,
	output logic      [15:0] conv1_result_o,
	output logic      [15:0] diff_result_o,
	output logic             core_busy_o
);
	logic [7:0] tick_q;
	logic [7:0] n_q;

	// Converters run from their own start source, requested or not
	always_ff @(posedge clock_i)
	begin
		tick_q <= (reset_i || tick_q >= period_i - 8'h01) ? 8'h00 : tick_q + 8'h01;
		conv0_done_o <= !reset_i && tick_q == 8'h00;
		conv1_done_o <= !reset_i && tick_q == 8'h00;
		if (reset_i)
			n_q <= 8'h00;
		else if (tick_q == 8'h00)
		begin
			n_q <= n_q + 8'h01;
			conv0_result_o <= {8'hA0, n_q};
			conv1_result_o <= {8'hB1, n_q};
			diff_result_o  <= {8'hD2, n_q};
		end
	end

	// Core steals every other cycle so the engine must find gaps
	assign core_busy_o = core_load_i & tick_q[0];
endmodule : conv_core_model

//--- test/engine_asserts.sv
// Port level checks for the result transfer engine
`timescale 1ns/1ps

module engine_asserts (
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_rdata_o,
	input  wire logic       core_onchip_busy_i,
	input  wire logic       mem_wr_o,
	input  wire logic       mem_offchip_o,
	input  wire logic       core_offchip_grant_o,
	input  wire logic       conv0_claimed_o,
	input  wire logic       conv1_claimed_o
);
	default clocking dc @(posedge clock_i); endclocking
	default disable iff (reset_i);

	wire cfg_wr = reg_wr_i && (reg_addr_i == xfer_pkg::REG_CFG);
	wire ptr_rd = reg_rd_i && (reg_addr_i == xfer_pkg::REG_IPTR);
	wire dat_rd = reg_rd_i && (reg_addr_i == xfer_pkg::REG_IDATA);

	// Pointer read, data read, pointer read on consecutive cycles
	sequence s_ptr_dat_ptr;
		ptr_rd ##1 dat_rd ##1 ptr_rd;
	endsequence

	////////////////////////////////////////////////////////////////
	a_onchip_core_idle: assert property (mem_wr_o && !mem_offchip_o |-> !$past(core_onchip_busy_i))
		else $error("on-chip write in a core cycle");
	a_offchip_halt_hold: assert property (mem_wr_o && mem_offchip_o |-> !core_offchip_grant_o)
		else $error("off-chip write while core owns memory");
	// Reset guard: the grant may drop during a short reset
	a_grant_cfg_only: assert property (!$past(reset_i) && !$past(cfg_wr) && !$past(cfg_wr, 2)
		|-> $stable(core_offchip_grant_o))
		else $error("grant moved without config write");
	a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");
	a_iptr_six_bits: assert property (ptr_rd |=> reg_rdata_o[7:6] == 2'h0)
		else $error("pointer wider than six bits");
	a_iptr_auto_step: assert property (s_ptr_dat_ptr |=> reg_rdata_o[5:0] == $past(reg_rdata_o[5:0], 2) + 6'h01)
		else $error("pointer did not step after data read");
	a_write_claimed: assert property (mem_wr_o |-> $past(conv0_claimed_o || conv1_claimed_o))
		else $error("write without a claimed converter");
	a_reset_quiet: assert property (disable iff (1'b0) reset_i |=> !mem_wr_o && !core_offchip_grant_o
		&& reg_rdata_o == 8'h00)
		else $error("outputs active after reset");
endmodule : engine_asserts

//--- test/testbench.sv
// Self-checking bench for the result transfer engine
`timescale 1ns/1ps

module testbench;
	logic        clock_i, reset_i, reg_wr_i, reg_rd_i, c0_done, c1_done, core_busy;
	logic        offchip_sel, mem_wr, mem_offchip, grant, cl0, cl1, core_load;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, period;
	logic [15:0] c0_res, c1_res, d_res, mem_addr, mem_data;
	logic [15:0] aq[$], dq[$];
	logic        oq[$];
	int          err_total, checks, cyc;

	result_transfer_engine DUT (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.conv0_done_i(c0_done), .conv0_result_i(c0_res), .conv1_done_i(c1_done),
		.conv1_result_i(c1_res), .diff_result_i(d_res), .core_onchip_busy_i(core_busy),
		.offchip_sel_i(offchip_sel), .mem_wr_o(mem_wr), .mem_addr_o(mem_addr), .mem_data_o(mem_data),
		.mem_offchip_o(mem_offchip), .core_offchip_grant_o(grant), .conv0_claimed_o(cl0),
		.conv1_claimed_o(cl1));

	conv_core_model partner (.clock_i(clock_i), .reset_i(reset_i), .period_i(period),
		.core_load_i(core_load), .conv0_done_o(c0_done), .conv1_done_o(c1_done),
		.conv0_result_o(c0_res), .conv1_result_o(c1_res), .diff_result_o(d_res), .core_busy_o(core_busy));

	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	task automatic check16(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check16

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_wr_i    <= 1'h1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge clock_i);
		reg_wr_i <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		reg_rd_i   <= 1'h1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_rd_i <= 1'h0;
		#1 d = reg_rdata_o;
	endtask : rd

	task automatic prog(input logic [7:0] b, input logic [7:0] p[$]);
		wr(xfer_pkg::REG_BOUND, b);
		wr(xfer_pkg::REG_IPTR, b);
		foreach (p[i])
			wr(xfer_pkg::REG_IDATA, p[i]);
	endtask : prog

	task automatic go(input logic [15:0] s, input logic [7:0] lim);
		wr(xfer_pkg::REG_START_HI, s[15:8]);
		wr(xfer_pkg::REG_START_LO, s[7:0]);
		wr(xfer_pkg::REG_LIMIT_HI, 8'h00);
		wr(xfer_pkg::REG_LIMIT_LO, lim);
		aq.delete();
		dq.delete();
		oq.delete();
		wr(xfer_pkg::REG_CTRL, 8'h80);
	endtask : go

	task automatic wait_recs(input int n);
		for (int i = 0; i < 4000 && aq.size() < n; i++)
			@(posedge clock_i);
		check16(16'(aq.size()), 16'(n));
	endtask : wait_recs

	// Only the high byte names the source; the low byte is a sample count
	task automatic recs(input logic [15:0] s, input int o, input logic [7:0] h[$]);
		foreach (h[k])
		begin
			check16(aq[o + k], s + 16'(2 * k));
			check16(dq[o + k] & 16'hFF00, {h[k], 8'h00});
		end
	endtask : recs

	////////////////////////////////////////////////////////////////
	task automatic t_store();
		logic [7:0] v0, v1, v2;
		wr(xfer_pkg::REG_IPTR, 8'h3E);
		wr(xfer_pkg::REG_IDATA, 8'h5A);
		wr(xfer_pkg::REG_IDATA, 8'hC3);
		wr(xfer_pkg::REG_IDATA, 8'h3C);
		wr(xfer_pkg::REG_IPTR, 8'h3E);
		// Back to back reads: each answer stands only in the cycle after its strobe
		@(posedge clock_i);
		reg_rd_i   <= 1'h1;
		reg_addr_i <= xfer_pkg::REG_IPTR;
		@(posedge clock_i);
		reg_addr_i <= xfer_pkg::REG_IDATA;
		#1 v0 = reg_rdata_o;
		@(posedge clock_i);
		reg_addr_i <= xfer_pkg::REG_IPTR;
		#1 v1 = reg_rdata_o;
		@(posedge clock_i);
		reg_rd_i <= 1'h0;
		#1 v2 = reg_rdata_o;
		check16({v0, v1}, 16'h3E5A);
		check16({8'h00, v2}, 16'h003F);
		rd(xfer_pkg::REG_IDATA, v0);
		rd(xfer_pkg::REG_IDATA, v1);
		rd(xfer_pkg::REG_IPTR, v2);
		check16({v0, v1}, 16'hC33C);
		check16({8'h00, v2}, 16'h0001);
		rd(8'hFF, v0);
		check16({8'h00, v0}, 16'h0000);
	endtask : t_store

	task automatic t_run();
		logic [7:0] v, w;
		logic [7:0] h[$] = '{8'hA0, 8'hB1, 8'hB1, 8'hA0, 8'hD2, 8'hD2, 8'hD2, 8'hB1};
		@(posedge clock_i);
		core_load <= 1'h1;
		prog(8'h00, '{8'h90, 8'h20, 8'hB0, 8'h40, 8'h50, 8'h70, 8'h00});
		go(16'h2468, 8'h02);
		wait_recs(16);
		recs(16'h2468, 0, h);
		recs(16'h2478, 8, h);
		v = 8'hFF;
		for (int i = 0; i < 60 && v[7] !== 1'h0; i++)
			rd(xfer_pkg::REG_CTRL, v);
		check16({8'h00, v & 8'hC0}, 16'h0040);
		repeat (40) @(posedge clock_i);
		check16(16'(aq.size()), 16'h0010);
		rd(xfer_pkg::REG_WPTR_HI, v);
		rd(xfer_pkg::REG_WPTR_LO, w);
		check16({v, w}, 16'h2488);
		rd(xfer_pkg::REG_COUNT_HI, v);
		rd(xfer_pkg::REG_COUNT_LO, w);
		check16({v, w}, 16'h0000);
		wr(xfer_pkg::REG_CTRL, 8'h20);
		rd(xfer_pkg::REG_CTRL, v);
		check16({8'h00, v}, 16'h0020);
		wr(xfer_pkg::REG_CTRL, 8'h00);
	endtask : t_run

	task automatic t_cont();
		logic [7:0] v;
		int         n;
		@(posedge clock_i);
		period    <= 8'h18;
		core_load <= 1'h0;
		prog(8'h08, '{8'h20, 8'h80});
		go(16'h0100, 8'h01);
		wait_recs(5);
		recs(16'h0100, 0, '{8'hB1, 8'hB1, 8'hB1, 8'hB1, 8'hB1});
		rd(xfer_pkg::REG_CTRL, v);
		check16({8'h00, v & 8'h80}, 16'h0080);
		wr(xfer_pkg::REG_CTRL, 8'h00);
		repeat (60) @(posedge clock_i);
		n = aq.size();
		rd(xfer_pkg::REG_CTRL, v);
		check16({8'h00, v & 8'h80}, 16'h0000);
		repeat (60) @(posedge clock_i);
		check16(16'(aq.size()), 16'(n));
	endtask : t_cont

	task automatic t_halt();
		logic [7:0] v;
		@(posedge clock_i);
		offchip_sel <= 1'h1;
		period      <= 8'h06;
		rd(xfer_pkg::REG_CFG, v);
		check16({8'h00, v & 8'h40}, 16'h0000);
		wr(xfer_pkg::REG_CFG, 8'h80);
		prog(8'h00, '{8'h10, 8'h00});
		go(16'h8000, 8'h01);
		repeat (100) @(posedge clock_i);
		#1;
		check16({15'h0000, grant}, 16'h0001);
		check16(16'(aq.size()), 16'h0000);
		wr(xfer_pkg::REG_CFG, 8'h00);
		wait_recs(1);
		recs(16'h8000, 0, '{8'hA0});
		#1;
		check16({15'h0000, oq[0]}, 16'h0001);
		check16({15'h0000, grant}, 16'h0000);
		// Results kept arriving while the write was held: warning then error for converter 0
		rd(xfer_pkg::REG_CTRL, v);
		check16({8'h00, v}, 16'h0049);
	endtask : t_halt

	////////////////////////////////////////////////////////////////
	initial
	begin
		clock_i = 1'h0;
		forever #50 clock_i = ~clock_i;
	end

	// Records and a hang limit well above the several hundred cycles needed
	always @(posedge clock_i)
	begin
		cyc++;
		if (mem_wr === 1'h1)
		begin
			aq.push_back(mem_addr);
			dq.push_back(mem_data);
			oq.push_back(mem_offchip);
		end
		if (cyc == 20000)
		begin
			err_total++;
			end_of_test();
		end
	end

	initial
	begin
		{reset_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {1'h1, 18'h00000};
		{offchip_sel, core_load, period} = {2'h0, 8'h06};
		repeat (3) @(posedge clock_i);
		reset_i <= 1'h0;
		t_store();
		t_run();
		t_cont();
		t_halt();
		end_of_test();
	end
endmodule : testbench

bind result_transfer_engine engine_asserts u_chk (.clock_i(clock_i), .reset_i(reset_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.core_onchip_busy_i(core_onchip_busy_i), .mem_wr_o(mem_wr_o), .mem_offchip_o(mem_offchip_o),
	.core_offchip_grant_o(core_offchip_grant_o), .conv0_claimed_o(conv0_claimed_o),
	.conv1_claimed_o(conv1_claimed_o));
